// ===== rtl/ppc_pkg.sv
// Constants and types for the port pin configuration block.
// Assumes a 32-bit AXI4-Lite register bus on aclk.
package ppc_pkg;
  localparam int unsigned PIN_COUNT = 8;
  localparam int unsigned FUNC_COUNT = 3;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OUT_EN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FUNC_BASE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_OPEN_DRAIN = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_PULL_UP = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_PULL_DOWN = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_INPUT_EN = 8'h38;
  localparam logic [ADDR_W-1:0] WORD_STEP = 8'h04;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_OUT_EN = 8'h00;
  localparam logic [7:0] RST_INPUT_EN = 8'h03;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] out_en;
    logic [FUNC_COUNT-1:0][7:0] func_sel;
    logic [7:0] open_drain;
    logic [7:0] pull_up;
    logic [7:0] pull_down;
    logic [7:0] input_en;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic [7:0] pad_pu;
    logic [7:0] pad_pd;
    logic [7:0] pad_ie;
    logic [7:0] alt_in;
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ppc_state_t;
endpackage

// ===== rtl/ppc_port_config.sv
// Pin configuration of an 8-bit port: function select, drive mode, pulls, input gate.
// Assumes an AXI4-Lite master on aclk; pad inputs are asynchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module ppc_port_config
  import ppc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PIN_COUNT-1:0] pad_in,
  output logic [PIN_COUNT-1:0] pad_out,
  output logic [PIN_COUNT-1:0] pad_oe,
  output logic [PIN_COUNT-1:0] pad_pull_up,
  output logic [PIN_COUNT-1:0] pad_pull_down,
  output logic [PIN_COUNT-1:0] pad_input_en,
  input wire logic [FUNC_COUNT-1:0][PIN_COUNT-1:0] alt_out,
  input wire logic [FUNC_COUNT-1:0][PIN_COUNT-1:0] alt_oe,
  output logic [PIN_COUNT-1:0] alt_in
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] low_byte(input logic [31:0] d, input logic [3:0] s,
                                          input logic [7:0] old);
    low_byte = s[0] ? d[7:0] : old;
  endfunction

  function automatic logic func_hit(input logic [ADDR_W-1:0] a, input int unsigned f);
    func_hit = (a == OFS_FUNC_BASE + ADDR_W'(f) * WORD_STEP);
  endfunction

  // ----------------------------------------
  // Register decode, shared by both channels
  // ----------------------------------------
  typedef enum {
    RSEL_NONE,
    RSEL_DATA,
    RSEL_OUT_EN,
    RSEL_FUNC,
    RSEL_OPEN_DRAIN,
    RSEL_PULL_UP,
    RSEL_PULL_DOWN,
    RSEL_INPUT_EN
  } ppc_reg_sel_t;

  function automatic ppc_reg_sel_t decode_reg(input logic [ADDR_W-1:0] a);
    decode_reg = RSEL_NONE;
    unique case (a)
      OFS_DATA: begin
        decode_reg = RSEL_DATA;
      end
      OFS_OUT_EN: begin
        decode_reg = RSEL_OUT_EN;
      end
      OFS_OPEN_DRAIN: begin
        decode_reg = RSEL_OPEN_DRAIN;
      end
      OFS_PULL_UP: begin
        decode_reg = RSEL_PULL_UP;
      end
      OFS_PULL_DOWN: begin
        decode_reg = RSEL_PULL_DOWN;
      end
      OFS_INPUT_EN: begin
        decode_reg = RSEL_INPUT_EN;
      end
      default: begin
        decode_reg = RSEL_NONE;
      end
    endcase
    for (int unsigned f = 0; f < FUNC_COUNT; f++) begin
      if (func_hit(a, f)) begin
        decode_reg = RSEL_FUNC;
      end
    end
  endfunction

  // Function register number; only meaningful with RSEL_FUNC
  function automatic int unsigned func_slot(input logic [ADDR_W-1:0] a);
    func_slot = 0;
    for (int unsigned f = 0; f < FUNC_COUNT; f++) begin
      if (func_hit(a, f)) begin
        func_slot = f;
      end
    end
  endfunction

  ppc_state_t q, d;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [7:0] sel_any;
    logic [7:0] f_out;
    logic [7:0] f_oe;
    logic [7:0] drv_data;
    logic [7:0] drv_oe;
    logic [7:0] rd;
    ppc_reg_sel_t wsel;
    ppc_reg_sel_t rsel;
    int unsigned wslot;
    int unsigned rslot;
    sel_any = '0;
    f_out = '0;
    f_oe = '0;
    drv_data = '0;
    drv_oe = '0;
    rd = '0;
    wsel = decode_reg(q.aw_addr);
    rsel = decode_reg(s_axi_araddr);
    wslot = func_slot(q.aw_addr);
    rslot = func_slot(s_axi_araddr);
    d = q;

    // Pad input synchroniser
    d.pin_meta = pad_in;
    d.pin_sync = q.pin_meta;

    // Function routing
    for (int f = 0; f < FUNC_COUNT; f++) begin
      sel_any = sel_any | q.func_sel[f];
      f_out = f_out | (q.func_sel[f] & alt_out[f]);
      f_oe = f_oe | (q.func_sel[f] & alt_oe[f]);
    end
    for (int p = 0; p < PIN_COUNT; p++) begin
      if (sel_any[p]) begin
        drv_data[p] = f_out[p];
        drv_oe[p] = f_oe[p];
      end else begin
        drv_data[p] = q.data[p];
        drv_oe[p] = q.out_en[p];
      end
      if (q.open_drain[p] && drv_data[p]) begin
        drv_oe[p] = 1'b0;
      end
    end
    d.pad_out = drv_data;
    d.pad_oe = drv_oe;
    d.pad_pu = q.pull_up;
    d.pad_pd = q.pull_down;
    d.pad_ie = q.input_en;
    d.alt_in = q.pin_sync & q.input_en & sel_any;

    // Write channel
    if (s_axi_awvalid && q.awready) begin
      d.aw_held = 1'b1;
      d.aw_addr = s_axi_awaddr;
      d.awready = 1'b0;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_held = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
      d.wready = 1'b0;
    end
    if (q.aw_held && q.w_held && !q.bvalid) begin
      d.bresp = RESP_OKAY;
      unique case (wsel)
        RSEL_DATA: begin
          d.data = low_byte(q.w_data, q.w_strb, q.data);
        end
        RSEL_OUT_EN: begin
          d.out_en = low_byte(q.w_data, q.w_strb, q.out_en);
        end
        RSEL_FUNC: begin
          d.func_sel[wslot] = low_byte(q.w_data, q.w_strb, q.func_sel[wslot]);
        end
        RSEL_OPEN_DRAIN: begin
          d.open_drain = low_byte(q.w_data, q.w_strb, q.open_drain);
        end
        RSEL_PULL_UP: begin
          d.pull_up = low_byte(q.w_data, q.w_strb, q.pull_up);
        end
        RSEL_PULL_DOWN: begin
          d.pull_down = low_byte(q.w_data, q.w_strb, q.pull_down);
        end
        RSEL_INPUT_EN: begin
          d.input_en = low_byte(q.w_data, q.w_strb, q.input_en);
        end
        RSEL_NONE: begin
          d.bresp = RESP_SLVERR;
        end
      endcase
      d.bvalid = 1'b1;
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end

    // Read channel
    if (s_axi_arvalid && q.arready) begin
      d.rresp = RESP_OKAY;
      unique case (rsel)
        RSEL_DATA: begin
          rd = q.pin_sync;
        end
        RSEL_OUT_EN: begin
          rd = q.out_en;
        end
        RSEL_FUNC: begin
          rd = q.func_sel[rslot];
        end
        RSEL_OPEN_DRAIN: begin
          rd = q.open_drain;
        end
        RSEL_PULL_UP: begin
          rd = q.pull_up;
        end
        RSEL_PULL_DOWN: begin
          rd = q.pull_down;
        end
        RSEL_INPUT_EN: begin
          rd = q.input_en;
        end
        RSEL_NONE: begin
          d.rresp = RESP_SLVERR;
        end
      endcase
      d.rdata = {24'h000000, rd};
      d.rvalid = 1'b1;
      d.arready = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.data <= RST_ZERO;
      q.out_en <= RST_OUT_EN;
      q.func_sel <= '0;
      q.open_drain <= RST_ZERO;
      q.pull_up <= RST_ZERO;
      q.pull_down <= RST_ZERO;
      q.input_en <= RST_INPUT_EN;
      q.pad_oe <= RST_OUT_EN;
      q.pad_ie <= RST_INPUT_EN;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign pad_out = q.pad_out;
  assign pad_oe = q.pad_oe;
  assign pad_pull_up = q.pad_pu;
  assign pad_pull_down = q.pad_pd;
  assign pad_input_en = q.pad_ie;
  assign alt_in = q.alt_in;

endmodule
`default_nettype wire

// ===== test/ppc_port_config_monitor.sv
// Port checker for ppc_port_config, bound to every instance.
// Assumes clk_en is held high while checked.
`timescale 1ns/1ps
`default_nettype none
module ppc_port_config_monitor
  import ppc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rready,
  input wire logic [PIN_COUNT-1:0] pad_pull_up,
  input wire logic [PIN_COUNT-1:0] pad_pull_down,
  input wire logic [PIN_COUNT-1:0] pad_input_en,
  input wire logic [PIN_COUNT-1:0] alt_in
);
  // ----
  // Bus and pad relations
  // ----
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en |=>
    s_axi_rvalid) else $error("read not answered");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_reset_pads: assert property ($rose(aresetn) |->
    {pad_pull_up, pad_pull_down, pad_input_en} == 24'h000003) else $error("pad reset");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_alt_in_gate: assert property ((alt_in & ~pad_input_en) == 8'h00)
    else $error("input not gated");
endmodule
bind ppc_port_config ppc_port_config_monitor ppc_mon_inst (.*);
`default_nettype wire

// ===== test/ppc_pin_model.sv
// Far side: pin wires with pulls, three peripheral functions.
// Unpulled undriven pins toggle each cycle.
`timescale 1ns/1ps
`default_nettype none
module ppc_pin_model
  import ppc_pkg::*;
(
  input wire logic aclk,
  input wire logic [PIN_COUNT-1:0] pad_out,
  input wire logic [PIN_COUNT-1:0] pad_oe,
  input wire logic [PIN_COUNT-1:0] pad_pull_up,
  input wire logic [PIN_COUNT-1:0] pad_pull_down,
  output logic [PIN_COUNT-1:0] pad_in,
  output logic [FUNC_COUNT-1:0][PIN_COUNT-1:0] alt_out,
  output logic [FUNC_COUNT-1:0][PIN_COUNT-1:0] alt_oe
);
  logic [PIN_COUNT-1:0] float_q = 8'h55;
  always @(posedge aclk) float_q <= ~float_q;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & pad_pull_up)
    | (~pad_oe & ~pad_pull_up & ~pad_pull_down & float_q);
  assign alt_out = {8'h0F, 8'h3C, 8'h5A};
  assign alt_oe = {3{8'hFF}};
endmodule
`default_nettype wire

// ===== test/ppc_port_config_tb.sv
// Bench for ppc_port_config: AXI4-Lite tasks and pad checks.
// Pin model on the pad side; clk_en held high.
`timescale 1ns/1ps
`default_nettype none
module ppc_port_config_tb;
  import ppc_pkg::*;
  logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [PIN_COUNT-1:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down;
  logic [PIN_COUNT-1:0] pad_input_en, alt_in;
  logic [FUNC_COUNT-1:0][PIN_COUNT-1:0] alt_out, alt_oe;
  logic [7:0] adr [7] = '{8'h08, 8'h0C, 8'h10, 8'h28, 8'h2C, 8'h30, 8'h38};
  logic [7:0] val [7] = '{8'h81, 8'h42, 8'h24, 8'hA5, 8'hF0, 8'h0F, 8'hFF};
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  logic slow_ready = 1'b0;
  ppc_port_config ppc_port_config_inst (.*);
  ppc_pin_model ppc_pin_model_inst (.*);
  // ----
  // Tasks and sequence
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !slow_ready;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdt(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !slow_ready;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic stop_test();
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    int i;
    clk_en = 1'b1;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
      s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    chk({8'h0, pad_pull_up, pad_pull_down, pad_input_en}, 32'h3);
    for (i = 0; i < 7; i++) begin
      rdt(adr[i]);
      chk(rd, {24'h0, (i == 6) ? RST_INPUT_EN : RST_ZERO});
    end
    slow_ready = 1'b1;
    for (i = 0; i < 7; i++) begin
      wr(adr[i], {24'hFFFFFF, val[i]});
      chk({30'h0, rs}, {30'h0, RESP_OKAY});
      rdt(adr[i]);
      chk(rd, {24'h0, val[i]});
      chk({30'h0, rs}, {30'h0, RESP_OKAY});
    end
    slow_ready = 1'b0;
    chk({8'h0, pad_pull_up, pad_pull_down, pad_input_en}, 32'hF00FFF);
    wr(8'h14, 32'h0);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    rdt(8'h14);
    chk({rd[31:2], rs}, {30'h0, RESP_SLVERR});
    for (i = 0; i < 4; i++) wr(adr[i], 32'h0);
    wr(OFS_DATA, 32'hA5);
    wr(OFS_OUT_EN, 32'h0F);
    repeat (6) @(posedge aclk);
    chk({16'h0, pad_oe, pad_out & pad_oe}, 32'h0F05);
    rdt(OFS_DATA);
    chk(rd, 32'hF5);
    rdt(OFS_OUT_EN);
    chk(rd, 32'h0F);
    wr(adr[3], 32'h0F);
    repeat (6) @(posedge aclk);
    chk({24'h0, pad_oe}, 32'h0A);
    wr(adr[3], 32'h0);
    wr(adr[0], 32'h01);
    wr(adr[1], 32'h10);
    wr(adr[2], 32'h80);
    repeat (6) @(posedge aclk);
    chk({8'h0, pad_oe, pad_out & pad_oe, alt_in}, 32'h9F1410);
    wr(adr[6], 32'h0);
    repeat (6) @(posedge aclk);
    chk({16'h0, pad_input_en, alt_in}, 32'h0);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk({8'h0, pad_pull_up, pad_pull_down, pad_input_en}, 32'h3);
    rdt(OFS_PULL_DOWN);
    chk(rd, {24'h0, RST_ZERO});
    rdt(OFS_INPUT_EN);
    chk(rd, {24'h0, RST_INPUT_EN});
    stop_test();
  end
endmodule
`default_nettype wire
